// file: sfcd_dev.sv
// Flash device end: samples the serial link and decodes array commands.
//
// The APB slave port and the placing of the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
module sfcd_dev (
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // Serial link
  sfcd_if.dev                    link,
  // Operation start toward the array
  output logic                   op_start,
  output sfcd_pkg::sfcd_op_e     op_code,
  output logic [31:0]            op_addr,
  // Programming data stream
  output logic                   prog_valid,
  output logic [7:0]             prog_byte,
  // Device state
  output logic                   write_latch,
  output logic                   address_length_bit,
  output logic [7:0]             ecc_status,
  // ECC error events from the array
  input  wire logic              ecc_single_evt,
  input  wire logic              ecc_double_evt
);

  // ----------------------------------------------------------------
  // Link synchronisers
  // ----------------------------------------------------------------
  logic [2:0] sclk_sync;
  logic [2:0] cs_sync;
  logic [2:0] mosi_sync;
  logic       sclk_lvl;
  logic       cs_lvl;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_sync <= 3'h0;
      cs_sync   <= 3'h7;
      mosi_sync <= 3'h0;
      sclk_lvl  <= 1'b0;
      cs_lvl    <= 1'b1;
    end else begin
      sclk_sync <= {sclk_sync[1:0], link.sclk};
      cs_sync   <= {cs_sync[1:0], link.cs_n};
      mosi_sync <= {mosi_sync[1:0], link.mosi};
      if (sclk_sync[1] == sclk_sync[2]) begin
        sclk_lvl <= sclk_sync[2];
      end
      if (cs_sync[1] == cs_sync[2]) begin
        cs_lvl <= cs_sync[2];
      end
    end
  end

  logic rise;
  logic frame_end;
  assign rise      = !cs_lvl && !sclk_lvl && sclk_sync[1] && sclk_sync[2];
  assign frame_end = !cs_lvl && cs_sync[1] && cs_sync[2];

  // ----------------------------------------------------------------
  // Opcode decode
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {SFCD_ADDR_NONE, SFCD_ADDR_MODE, SFCD_ADDR_FOUR} sfcd_alen_e;

  function automatic logic [5:0] sfcd_decode(input logic [7:0] b);
    unique case (b)
      sfcd_pkg::OP_RD_ECC_AM:  sfcd_decode = {SFCD_ADDR_MODE, sfcd_pkg::SFCD_OP_RD_ECC};
      sfcd_pkg::OP_RD_ECC_4B:  sfcd_decode = {SFCD_ADDR_FOUR, sfcd_pkg::SFCD_OP_RD_ECC};
      sfcd_pkg::OP_CLR_ECC:    sfcd_decode = {SFCD_ADDR_NONE, sfcd_pkg::SFCD_OP_CLR_ECC};
      sfcd_pkg::OP_RD_AM:      sfcd_decode = {SFCD_ADDR_MODE, sfcd_pkg::SFCD_OP_READ};
      sfcd_pkg::OP_RD_4B:      sfcd_decode = {SFCD_ADDR_FOUR, sfcd_pkg::SFCD_OP_READ};
      sfcd_pkg::OP_FAST_RD_AM: sfcd_decode = {SFCD_ADDR_MODE, sfcd_pkg::SFCD_OP_FAST_READ};
      sfcd_pkg::OP_PROG_AM:    sfcd_decode = {SFCD_ADDR_MODE, sfcd_pkg::SFCD_OP_PROG};
      sfcd_pkg::OP_PROG_4B:    sfcd_decode = {SFCD_ADDR_FOUR, sfcd_pkg::SFCD_OP_PROG};
      sfcd_pkg::OP_SEC_ERS_AM: sfcd_decode = {SFCD_ADDR_MODE, sfcd_pkg::SFCD_OP_SEC_ERS};
      sfcd_pkg::OP_SEC_ERS_4B: sfcd_decode = {SFCD_ADDR_FOUR, sfcd_pkg::SFCD_OP_SEC_ERS};
      sfcd_pkg::OP_CHIP_ERS_A: sfcd_decode = {SFCD_ADDR_NONE, sfcd_pkg::SFCD_OP_CHIP_ERS};
      sfcd_pkg::OP_CHIP_ERS_B: sfcd_decode = {SFCD_ADDR_NONE, sfcd_pkg::SFCD_OP_CHIP_ERS};
      sfcd_pkg::OP_ERS_CHECK:  sfcd_decode = {SFCD_ADDR_MODE, sfcd_pkg::SFCD_OP_ERS_CHECK};
      sfcd_pkg::OP_SUSPEND:    sfcd_decode = {SFCD_ADDR_NONE, sfcd_pkg::SFCD_OP_SUSPEND};
      sfcd_pkg::OP_RESUME:     sfcd_decode = {SFCD_ADDR_NONE, sfcd_pkg::SFCD_OP_RESUME};
      sfcd_pkg::OP_WREN:       sfcd_decode = {SFCD_ADDR_NONE, sfcd_pkg::SFCD_OP_WREN};
      sfcd_pkg::OP_LEAVE_4B:   sfcd_decode = {SFCD_ADDR_NONE, sfcd_pkg::SFCD_OP_LEAVE_4B};
      default:                 sfcd_decode = {SFCD_ADDR_NONE, sfcd_pkg::SFCD_OP_NONE};
    endcase
  endfunction : sfcd_decode

  function automatic logic sfcd_guarded(input sfcd_pkg::sfcd_op_e o);
    sfcd_guarded = (o == sfcd_pkg::SFCD_OP_CLR_ECC) || (o == sfcd_pkg::SFCD_OP_PROG) ||
                   (o == sfcd_pkg::SFCD_OP_SEC_ERS) || (o == sfcd_pkg::SFCD_OP_CHIP_ERS);
  endfunction : sfcd_guarded

  // ----------------------------------------------------------------
  // Frame sequencer
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ST_OPCODE, ST_ADDR, ST_DATA, ST_IGNORE} sfcd_st_e;

  sfcd_st_e            state;
  logic [2:0]          bit_cnt;
  logic [2:0]          byte_cnt;
  logic [7:0]          shreg;
  logic [7:0]          next_byte;
  sfcd_pkg::sfcd_op_e  cur_op;
  logic [2:0]          addr_bytes;
  logic [5:0]          dec;
  sfcd_pkg::sfcd_op_e  dec_op;
  logic [2:0]          dec_len;

  assign next_byte = {shreg[6:0], mosi_sync[2]};
  assign dec       = sfcd_decode(next_byte);
  assign dec_op    = sfcd_pkg::sfcd_op_e'(dec[3:0]);
  assign dec_len   = (dec[5:4] == SFCD_ADDR_FOUR) ? 3'd4 :
                     (dec[5:4] == SFCD_ADDR_MODE) ? (address_length_bit ? 3'd4 : 3'd3) : 3'd0;

  logic byte_done;
  assign byte_done = rise && (bit_cnt == 3'd7);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state    <= ST_OPCODE;
      bit_cnt  <= 3'd0;
      byte_cnt <= 3'd0;
      shreg    <= 8'h00;
      cur_op   <= sfcd_pkg::SFCD_OP_NONE;
      addr_bytes <= 3'd0;
      op_addr  <= 32'h0;
    end else if (cs_lvl) begin
      state    <= ST_OPCODE;
      bit_cnt  <= 3'd0;
      byte_cnt <= 3'd0;
    end else if (rise) begin
      shreg   <= next_byte;
      bit_cnt <= bit_cnt + 3'd1;
      if (byte_done) begin
        unique case (state)
          ST_OPCODE: begin
            cur_op     <= dec_op;
            addr_bytes <= dec_len;
            byte_cnt   <= 3'd0;
            op_addr    <= 32'h0;
            if (dec_op == sfcd_pkg::SFCD_OP_NONE) begin
              state <= ST_IGNORE;
            end else if (sfcd_guarded(dec_op) && !write_latch) begin
              state <= ST_IGNORE;
            end else if (dec_len != 3'd0) begin
              state <= ST_ADDR;
            end else begin
              state <= ST_DATA;
            end
          end
          ST_ADDR: begin
            op_addr  <= {op_addr[23:0], next_byte};
            byte_cnt <= byte_cnt + 3'd1;
            if (byte_cnt + 3'd1 == addr_bytes) begin
              state <= ST_DATA;
            end
          end
          ST_DATA:   state <= ST_DATA;
          ST_IGNORE: state <= ST_IGNORE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Operation start and programming data
  // ----------------------------------------------------------------
  logic addr_last;
  assign addr_last = byte_done && (state == ST_ADDR) && (byte_cnt + 3'd1 == addr_bytes);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_start <= 1'b0;
      op_code  <= sfcd_pkg::SFCD_OP_NONE;
    end else begin
      op_start <= 1'b0;
      if (addr_last && (cur_op != sfcd_pkg::SFCD_OP_PROG)) begin
        op_start <= 1'b1;
        op_code  <= cur_op;
      end else if (frame_end && (state == ST_DATA) &&
                   ((addr_bytes == 3'd0) || (cur_op == sfcd_pkg::SFCD_OP_PROG))) begin
        op_start <= 1'b1;
        op_code  <= cur_op;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prog_valid <= 1'b0;
      prog_byte  <= 8'h00;
    end else begin
      prog_valid <= byte_done && (state == ST_DATA) && (cur_op == sfcd_pkg::SFCD_OP_PROG);
      if (byte_done) begin
        prog_byte <= next_byte;
      end
    end
  end

  // ----------------------------------------------------------------
  // Write latch, address length and ECC status
  // ----------------------------------------------------------------
  logic done_now;
  assign done_now = frame_end && (state == ST_DATA);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      write_latch <= 1'b0;
    end else if (done_now && (cur_op == sfcd_pkg::SFCD_OP_WREN)) begin
      write_latch <= 1'b1;
    end else if (done_now && sfcd_guarded(cur_op)) begin
      write_latch <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      address_length_bit <= sfcd_pkg::ADDR_LEN_RESET;
    end else if (done_now && (cur_op == sfcd_pkg::SFCD_OP_LEAVE_4B)) begin
      address_length_bit <= 1'b0;
    end
  end

  logic clr_ecc;
  assign clr_ecc = done_now && (cur_op == sfcd_pkg::SFCD_OP_CLR_ECC);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ecc_status <= sfcd_pkg::ECC_STATUS_RESET;
    end else begin
      ecc_status[sfcd_pkg::ECC_SBC_BIT] <= ecc_single_evt ||
                                            (ecc_status[sfcd_pkg::ECC_SBC_BIT] && !clr_ecc);
      ecc_status[sfcd_pkg::ECC_DBD_BIT] <= ecc_double_evt ||
                                            (ecc_status[sfcd_pkg::ECC_DBD_BIT] && !clr_ecc);
    end
  end

endmodule : sfcd_dev
`default_nettype wire

// file: sfcd_pkg.sv
// Package of opcodes, address-length and interrupt layout for the flash command decoder pair.
package sfcd_pkg;

  // ----------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_RD_ECC_AM   = 8'h19;
  localparam logic [7:0] OP_RD_ECC_4B   = 8'h18;
  localparam logic [7:0] OP_CLR_ECC     = 8'h1B;
  localparam logic [7:0] OP_RD_AM       = 8'h03;
  localparam logic [7:0] OP_RD_4B       = 8'h13;
  localparam logic [7:0] OP_FAST_RD_AM  = 8'h0B;
  localparam logic [7:0] OP_PROG_AM     = 8'h02;
  localparam logic [7:0] OP_PROG_4B     = 8'h12;
  localparam logic [7:0] OP_SEC_ERS_AM  = 8'hD8;
  localparam logic [7:0] OP_SEC_ERS_4B  = 8'hDC;
  localparam logic [7:0] OP_CHIP_ERS_A  = 8'h60;
  localparam logic [7:0] OP_CHIP_ERS_B  = 8'hC7;
  localparam logic [7:0] OP_ERS_CHECK   = 8'hD0;
  localparam logic [7:0] OP_SUSPEND     = 8'h75;
  localparam logic [7:0] OP_RESUME      = 8'h7A;
  localparam logic [7:0] OP_WREN        = 8'h06;
  localparam logic [7:0] OP_LEAVE_4B    = 8'hB8;

  // ----------------------------------------------------------------
  // Device fields
  // ----------------------------------------------------------------
  localparam int ECC_SBC_BIT = 3;
  localparam int ECC_DBD_BIT = 4;
  localparam logic [7:0] ECC_STATUS_RESET = 8'h00;
  localparam logic       ADDR_LEN_RESET   = 1'b0;
  localparam logic [7:0] ERASED_BYTE      = 8'hFF;

  // ----------------------------------------------------------------
  // Operation codes handed to the array side
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    SFCD_OP_NONE, SFCD_OP_RD_ECC, SFCD_OP_CLR_ECC, SFCD_OP_READ, SFCD_OP_FAST_READ,
    SFCD_OP_PROG, SFCD_OP_SEC_ERS, SFCD_OP_CHIP_ERS, SFCD_OP_ERS_CHECK,
    SFCD_OP_SUSPEND, SFCD_OP_RESUME, SFCD_OP_WREN, SFCD_OP_LEAVE_4B
  } sfcd_op_e;

  // ----------------------------------------------------------------
  // Host APB registers (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_TXDATA = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_IRQ    = 8'h10;
  localparam logic [7:0] REG_MASK   = 8'h14;
  localparam int CTRL_OP_LSB   = 0;
  localparam int CTRL_FOUR_BIT = 8;
  localparam int CTRL_DLEN_LSB = 16;
  localparam int CTRL_GO_BIT   = 31;
  localparam int DIV_HALF      = 4;
  localparam int IRQ_DONE_BIT  = 0;

endpackage : sfcd_pkg

// file: sfcd_if.sv
// Interface of the single-line serial link between host and flash device.
`timescale 1ns/100ps
`default_nettype none
interface sfcd_if;
  logic sclk;
  logic cs_n;
  logic mosi;

  modport host (output sclk, output cs_n, output mosi);
  modport dev  (input sclk, input cs_n, input mosi);
endinterface : sfcd_if
`default_nettype wire

// file: sfcd_host.sv
// Host end: APB-programmed serial controller that sends flash command frames.
`timescale 1ns/100ps
`default_nettype none
module sfcd_host (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Interrupt
  output logic             irq,
  // Serial link
  sfcd_if.host             link
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0]  opcode;
  logic        four_bytes;
  logic [7:0]  data_len;
  logic [31:0] addr;
  logic [31:0] txdata;
  logic        busy;
  logic        irq_done;
  logic        irq_mask;
  logic        done_evt;

  logic wr;
  logic rd_ok;
  assign wr    = psel && penable && pwrite;
  assign rd_ok = (paddr == sfcd_pkg::REG_CTRL) || (paddr == sfcd_pkg::REG_ADDR) ||
                 (paddr == sfcd_pkg::REG_TXDATA) || (paddr == sfcd_pkg::REG_STATUS) ||
                 (paddr == sfcd_pkg::REG_IRQ) || (paddr == sfcd_pkg::REG_MASK);

  logic go;
  assign go = wr && (paddr == sfcd_pkg::REG_CTRL) && pwdata[sfcd_pkg::CTRL_GO_BIT] && !busy;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opcode     <= 8'h00;
      four_bytes <= 1'b0;
      data_len   <= 8'h00;
      addr       <= 32'h0;
      txdata     <= 32'h0;
      irq_mask   <= 1'b0;
    end else if (wr) begin
      if (paddr == sfcd_pkg::REG_CTRL && !busy) begin
        opcode     <= pwdata[sfcd_pkg::CTRL_OP_LSB +: 8];
        four_bytes <= pwdata[sfcd_pkg::CTRL_FOUR_BIT];
        data_len   <= pwdata[sfcd_pkg::CTRL_DLEN_LSB +: 8];
      end
      if (paddr == sfcd_pkg::REG_ADDR && !busy) begin
        addr <= pwdata;
      end
      if (paddr == sfcd_pkg::REG_TXDATA && !busy) begin
        txdata <= pwdata;
      end
      if (paddr == sfcd_pkg::REG_MASK) begin
        irq_mask <= pwdata[sfcd_pkg::IRQ_DONE_BIT];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_done <= 1'b0;
    end else if (done_evt) begin
      irq_done <= 1'b1;
    end else if (wr && paddr == sfcd_pkg::REG_IRQ && pwdata[sfcd_pkg::IRQ_DONE_BIT]) begin
      irq_done <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      irq     <= 1'b0;
    end else begin
      irq     <= irq_done && irq_mask;
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !rd_ok;
      if (psel && !penable && !pwrite) begin
        unique case (paddr)
          sfcd_pkg::REG_CTRL:   prdata <= {busy, 7'h0, data_len, 7'h0, four_bytes, opcode};
          sfcd_pkg::REG_ADDR:   prdata <= addr;
          sfcd_pkg::REG_TXDATA: prdata <= txdata;
          sfcd_pkg::REG_STATUS: prdata <= {31'h0, busy};
          sfcd_pkg::REG_IRQ:    prdata <= {31'h0, irq_done};
          sfcd_pkg::REG_MASK:   prdata <= {31'h0, irq_mask};
          default:              prdata <= 32'h0;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Serial engine
  // ----------------------------------------------------------------
  logic [2:0]  div_cnt;
  logic [71:0] shift;
  logic [9:0]  bits_left;
  logic        phase_hi;

  function automatic logic [9:0] sfcd_bits(input logic [7:0] op, input logic fb, input logic [7:0] dl);
    logic [9:0] n;
    n = 10'd8;
    if (op == sfcd_pkg::OP_RD_ECC_4B || op == sfcd_pkg::OP_RD_4B || op == sfcd_pkg::OP_PROG_4B ||
        op == sfcd_pkg::OP_SEC_ERS_4B) begin
      n = n + 10'd32;
    end else if (op == sfcd_pkg::OP_RD_ECC_AM || op == sfcd_pkg::OP_RD_AM || op == sfcd_pkg::OP_FAST_RD_AM ||
                 op == sfcd_pkg::OP_PROG_AM || op == sfcd_pkg::OP_SEC_ERS_AM || op == sfcd_pkg::OP_ERS_CHECK) begin
      n = n + (fb ? 10'd32 : 10'd24);
    end
    sfcd_bits = n + {4'h0, dl[2:0], 3'h0};
  endfunction : sfcd_bits

  logic [9:0] total;
  assign total = sfcd_bits(opcode, four_bytes, data_len);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy      <= 1'b0;
      div_cnt   <= 3'd0;
      shift     <= 72'h0;
      bits_left <= 10'd0;
      phase_hi  <= 1'b0;
      done_evt  <= 1'b0;
      link.sclk <= 1'b0;
      link.cs_n <= 1'b1;
      link.mosi <= 1'b0;
    end else begin
      done_evt <= 1'b0;
      if (!busy) begin
        if (go) begin
          busy <= 1'b1;
        end
      end else if (link.cs_n && bits_left == 10'd0 && !phase_hi) begin
        if (total == 10'd0) begin
          busy <= 1'b0;
        end else begin
          shift     <= (sfcd_bits(opcode, four_bytes, 8'h00) == 10'd40) ? {opcode, addr, txdata} :
                       {opcode, addr[23:0], txdata, 8'h00};
          bits_left <= total;
          link.cs_n <= 1'b0;
          phase_hi  <= 1'b1;
          div_cnt   <= 3'd0;
        end
      end else begin
        div_cnt <= div_cnt + 3'd1;
        if (div_cnt == 3'(sfcd_pkg::DIV_HALF - 1)) begin
          div_cnt <= 3'd0;
          if (bits_left == 10'd0 && !link.sclk) begin
            link.cs_n <= 1'b1;
            busy      <= 1'b0;
            phase_hi  <= 1'b0;
            done_evt  <= 1'b1;
          end else if (!link.sclk && phase_hi) begin
            link.mosi <= shift[71];
            shift     <= {shift[70:0], 1'b0};
            link.sclk <= 1'b0;
            phase_hi  <= 1'b0;
          end else if (!link.sclk) begin
            link.sclk <= 1'b1;
            bits_left <= bits_left - 10'd1;
          end else begin
            link.sclk <= 1'b0;
            phase_hi  <= 1'b1;
          end
        end
      end
    end
  end

endmodule : sfcd_host
`default_nettype wire

// file: sfcd_props.sv
// Checker of link framing and device decode outcomes.
`timescale 1ns/100ps
`default_nettype none
module sfcd_props (
  // Clock and reset
  input wire logic               pclk,
  input wire logic               presetn,
  // Link and device state
  input wire logic               sclk,
  input wire logic               cs_n,
  input wire logic               mosi,
  input wire logic               op_start,
  input wire sfcd_pkg::sfcd_op_e op_code,
  input wire logic               write_latch,
  input wire logic               address_length_bit,
  input wire logic [7:0]         ecc_status
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_SCLK_HIGH: assert property ($rose(sclk) |-> sclk[*4] ##1 !sclk)
    else $error("link clock high phase wrong");
  AST_SCLK_LOW: assert property ($fell(sclk) |-> (!sclk)[*4])
    else $error("link clock low phase wrong");
  AST_MOSI_HOLD: assert property ($rose(sclk) && !cs_n |-> $stable(mosi))
    else $error("data moved at sampling edge");
  AST_FRAME_IDLE: assert property ($fell(cs_n) |-> !sclk)
    else $error("frame opened with clock high");
  AST_START_PULSE: assert property (op_start |=> !op_start)
    else $error("start longer than one cycle");
  AST_WREN: assert property (op_start && op_code == sfcd_pkg::SFCD_OP_WREN |-> ##[0:2] write_latch)
    else $error("write latch not set");
  AST_SHORT_CMD: assert property (op_start && op_code inside {sfcd_pkg::SFCD_OP_SUSPEND,
    sfcd_pkg::SFCD_OP_RESUME, sfcd_pkg::SFCD_OP_CHIP_ERS} |-> cs_n)
    else $error("short command started inside frame");
  AST_ADDR_LEN: assert property (!address_length_bit)
    else $error("address length bit set");
  AST_ECC_CLR: assert property (op_start && op_code == sfcd_pkg::SFCD_OP_CLR_ECC
    |-> ##[0:2] ecc_status[4:3] == 2'b00)
    else $error("ecc flags not cleared");
  AST_GUARD_LATCH: assert property (op_start && op_code inside {sfcd_pkg::SFCD_OP_PROG,
    sfcd_pkg::SFCD_OP_SEC_ERS, sfcd_pkg::SFCD_OP_CHIP_ERS} |-> ##[0:12] !write_latch)
    else $error("write latch kept after guarded op");
endmodule : sfcd_props
`default_nettype wire

// file: spi_flash_array_command_decoder_tb_top.sv
// Testbench joining host and device ends over the serial link.
`timescale 1ns/100ps
`default_nettype none
module spi_flash_array_command_decoder_tb_top;
  logic               pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq, perr;
  logic               ecc_single_evt = 0, ecc_double_evt = 0, op_start, prog_valid, write_latch, address_length_bit;
  logic [7:0]         paddr = 0, prog_byte, ecc_status;
  logic [31:0]        pwdata = 0, prdata, rd, op_addr, prog_word;
  sfcd_pkg::sfcd_op_e op_code;
  int                 n_mismatch, comparisons, n_start, nst;
  sfcd_if lnk();
  sfcd_host sfcd_host_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .link(lnk));
  sfcd_dev sfcd_dev_i (.pclk(pclk), .presetn(presetn), .link(lnk), .op_start(op_start), .op_code(op_code),
    .op_addr(op_addr), .prog_valid(prog_valid), .prog_byte(prog_byte), .write_latch(write_latch),
    .address_length_bit(address_length_bit), .ecc_status(ecc_status), .ecc_single_evt(ecc_single_evt),
    .ecc_double_evt(ecc_double_evt));
  sfcd_props sfcd_props_i (.pclk(pclk), .presetn(presetn), .sclk(lnk.sclk), .cs_n(lnk.cs_n), .mosi(lnk.mosi),
    .op_start(op_start), .op_code(op_code), .write_latch(write_latch),
    .address_length_bit(address_length_bit), .ecc_status(ecc_status));
  always #5 pclk = ~pclk;
  always @(posedge pclk) begin
    if (op_start) n_start <= n_start + 1;
    if (prog_valid) prog_word <= {prog_word[23:0], prog_byte};
  end
  task automatic complete_run;
    if (n_mismatch == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : complete_run
  task automatic chk(input logic ok, input string m);
    comparisons++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata; perr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (i == 20) begin chk(1'b0, "bus hang"); complete_run(); end
    @(posedge pclk);
  endtask : apb
  task automatic cmd(input logic [7:0] op, input logic four, input logic [7:0] nd, input logic [31:0] a, d);
    int i, s;
    s = n_start;
    apb(1, sfcd_pkg::REG_ADDR, a);
    apb(1, sfcd_pkg::REG_TXDATA, d);
    apb(1, sfcd_pkg::REG_CTRL, {1'b1, 7'h00, nd, 7'h00, four, op});
    for (i = 0; i < 3000 && irq !== 1'b1; i++) @(posedge pclk);
    if (i == 3000) begin chk(1'b0, "frame hang"); complete_run(); end
    repeat (8) @(posedge pclk);
    apb(1, sfcd_pkg::REG_IRQ, 32'h1);
    nst = n_start - s;
  endtask : cmd
  task automatic t_reads;
    logic [7:0] op[6] = '{8'h19, 8'h18, 8'h03, 8'h13, 8'h0B, 8'hD0};
    logic f[6] = '{0, 1, 0, 1, 0, 0};
    sfcd_pkg::sfcd_op_e c[6] = '{sfcd_pkg::SFCD_OP_RD_ECC, sfcd_pkg::SFCD_OP_RD_ECC, sfcd_pkg::SFCD_OP_READ,
      sfcd_pkg::SFCD_OP_READ, sfcd_pkg::SFCD_OP_FAST_READ, sfcd_pkg::SFCD_OP_ERS_CHECK};
    for (int k = 0; k < 6; k++) begin
      cmd(op[k], f[k], 8'h00, f[k] ? 32'h12345678 : 32'h00ABCDEF, 32'h0);
      chk(nst == 1 && op_code === c[k] && op_addr === (f[k] ? 32'h12345678 : 32'h00ABCDEF), "read decode");
    end
  endtask : t_reads
  task automatic t_guard;
    logic [7:0] op[4] = '{8'h1B, 8'h02, 8'hD8, 8'h60};
    foreach (op[k]) begin
      cmd(op[k], 1'b0, 8'h00, 32'h00001200, 32'h0);
      chk(nst == 0, "guarded op ran without latch");
    end
    cmd(8'h06, 1'b0, 8'h00, 32'h0, 32'h0);
    chk(nst == 1 && write_latch === 1'b1, "latch not set");
    cmd(8'h02, 1'b0, 8'h04, 32'h00001200, 32'hC3A55A3C);
    chk(op_code === sfcd_pkg::SFCD_OP_PROG && prog_word === 32'hC3A55A3C && write_latch === 1'b0, "program");
    cmd(8'h06, 1'b0, 8'h00, 32'h0, 32'h0);
    cmd(8'h12, 1'b1, 8'h01, 32'h12345678, 32'h96969696);
    chk(op_addr === 32'h12345678 && prog_word[7:0] === 8'h96, "program four byte");
  endtask : t_guard
  task automatic t_erase;
    logic [7:0] op[4] = '{8'hD8, 8'hDC, 8'h60, 8'hC7};
    logic f[4] = '{0, 1, 0, 0};
    foreach (op[k]) begin
      cmd(8'h06, 1'b0, 8'h00, 32'h0, 32'h0);
      cmd(op[k], f[k], 8'h00, 32'h00020000, 32'h0);
      chk(nst == 1 && op_code === (k < 2 ? sfcd_pkg::SFCD_OP_SEC_ERS : sfcd_pkg::SFCD_OP_CHIP_ERS), "erase");
    end
  endtask : t_erase
  task automatic t_ecc;
    ecc_single_evt <= 1'b1; ecc_double_evt <= 1'b1;
    @(posedge pclk);
    ecc_single_evt <= 1'b0; ecc_double_evt <= 1'b0;
    repeat (2) @(posedge pclk);
    chk(ecc_status[4:3] === 2'b11, "ecc flags not set");
    cmd(8'h06, 1'b0, 8'h00, 32'h0, 32'h0);
    cmd(8'h1B, 1'b0, 8'h00, 32'h0, 32'h0);
    chk(op_code === sfcd_pkg::SFCD_OP_CLR_ECC && ecc_status[4:3] === 2'b00, "ecc clear");
  endtask : t_ecc
  task automatic t_susp;
    logic [7:0] op[3] = '{8'h75, 8'h7A, 8'hB8};
    sfcd_pkg::sfcd_op_e c[3] = '{sfcd_pkg::SFCD_OP_SUSPEND, sfcd_pkg::SFCD_OP_RESUME, sfcd_pkg::SFCD_OP_LEAVE_4B};
    foreach (op[k]) begin
      cmd(op[k], 1'b0, 8'h00, 32'h0, 32'h0);
      chk(nst == 1 && op_code === c[k] && address_length_bit === 1'b0, "suspend resume");
    end
  endtask : t_susp
  task automatic t_regs;
    int i;
    apb(0, 8'h3C, 32'h0);
    chk(perr === 1'b1, "unmapped not refused");
    apb(1, sfcd_pkg::REG_MASK, 32'h0);
    apb(1, sfcd_pkg::REG_CTRL, 32'h80000075);
    for (i = 0; i < 200; i++) begin
      apb(0, sfcd_pkg::REG_STATUS, 32'h0);
      if (rd[0] === 1'b0) break;
    end
    apb(0, sfcd_pkg::REG_IRQ, 32'h0);
    chk(i < 200 && rd[0] === 1'b1 && irq === 1'b0, "masked irq");
    apb(1, sfcd_pkg::REG_MASK, 32'h1);
    @(posedge pclk);
    chk(irq === 1'b1, "unmasked irq");
    apb(1, sfcd_pkg::REG_IRQ, 32'h1);
    @(posedge pclk);
    chk(irq === 1'b0, "irq clear");
  endtask : t_regs
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_reads();
    t_guard();
    t_erase();
    t_ecc();
    t_susp();
    complete_run();
  end
endmodule : spi_flash_array_command_decoder_tb_top
`default_nettype wire
